// file: disp_cmd_pkg.sv
// constants for the bank 0 enhancement and deep standby command registers
// assumes commands and parameters arrive already framed by the host link
package disp_cmd_pkg;

  // ----------------------------------------------------------------
  // command codes, packet path byte and serial path high byte
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_SKIN_TONE  = 8'he4;
  localparam logic [7:0] CMD_NVM_ADDR   = 8'hea;
  localparam logic [7:0] CMD_BACKLIGHT  = 8'hee;
  localparam logic [7:0] CMD_STANDBY    = 8'hff;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int         SKIN_EN_BIT    = 4;
  localparam int         SKIN_LVL_LSB   = 0;
  localparam int         SKIN_LVL_W     = 2;
  localparam int         NVM_EN_BIT     = 0;
  localparam int         BL_ON_BIT      = 0;
  localparam int         BL_SEL_BIT     = 4;
  localparam int         DS_FLAG_BIT    = 7;
  localparam int         BYTE_W         = 8;
  localparam int         WORD_W         = 16;

  // ----------------------------------------------------------------
  // deep standby parameter sequence
  // ----------------------------------------------------------------
  localparam int              SEQ_KEY_CNT    = 5;
  localparam logic [39:0]     SEQ_KEYS       = {8'h00, 8'h00, 8'h00, 8'h01, 8'h77};
  localparam logic [7:0]      SEQ_ACTIVE_IDX = 8'h04;
  localparam logic [7:0]      SEQ_ENABLE_IDX = 8'h05;
  localparam logic [7:0]      SEQ_IDX_MAX    = 8'hff;
  localparam logic [7:0]      FLAG_MASK      = 8'h80;

  typedef enum logic {
    PATH_PACKET = 1'b0,
    PATH_SERIAL = 1'b1
  } path_e;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_PARAM = 1'b1
  } cmd_state_e;

endpackage

// file: standby_key_tracker.sv
// tracks which key parameters of the deep standby sequence matched
// assumes param_we_i is a one-cycle strobe on clk_i
`timescale 1ns/100ps
`default_nettype none

module standby_key_tracker
  import disp_cmd_pkg::*;
#(
  parameter int KEY_CNT = SEQ_KEY_CNT
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       clear_i,
  input  wire logic       param_we_i,
  input  wire logic [7:0] idx_i,
  input  wire logic [7:0] data_i,
  output logic            lead_ok_o,
  output logic            keys_ok_o
);

  initial begin
    if (KEY_CNT != SEQ_KEY_CNT) begin
      $error("standby_key_tracker: KEY_CNT must equal the key count");
    end
  end

  logic [KEY_CNT-1:0] match_reg;
  logic [KEY_CNT-1:0] match_next;

  // ----------------------------------------------------------------
  // per key match flags
  // ----------------------------------------------------------------
  genvar k;
  generate
    for (k = 0; k < KEY_CNT; k++) begin : g_key
      logic [7:0] want;
      logic [7:0] mask;
      assign want = SEQ_KEYS[k*BYTE_W +: BYTE_W];
      // the last key byte carries the active flag in its top bit
      assign mask = (8'(k) == SEQ_ACTIVE_IDX) ? ~FLAG_MASK : 8'hff;
      always_comb begin
        match_next[k] = match_reg[k];
        if (clear_i) begin
          match_next[k] = 1'b0;
        end else if (param_we_i && (idx_i == 8'(k))) begin
          match_next[k] = ((data_i & mask) == want);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      match_reg <= '0;
    end else begin
      match_reg <= match_next;
    end
  end

  assign lead_ok_o = &match_reg[KEY_CNT-2:0];
  assign keys_ok_o = &match_reg;

endmodule

`default_nettype wire

// file: display_enhance_standby_cmd_regs.sv
// bank 0 write-only command registers: skin tone, nvm address enable,
// backlight output control and the deep standby parameter sequence
// assumes the host link delivers framed words on clk_i, one per wr_i pulse
`timescale 1ns/100ps
`default_nettype none

module display_enhance_standby_cmd_regs
  import disp_cmd_pkg::*;
#(
  parameter int DATA_W = WORD_W
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              sw_reset_i,
  input  wire logic              path_serial_i,
  input  wire logic              wr_i,
  input  wire logic              dc_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  output logic                   skin_tone_enable_o,
  output logic [1:0]             skin_tone_level_o,
  output logic                   nvm_addr_set_enable_o,
  output logic                   backlight_output_on_o,
  output logic                   backlight_level_select_o,
  output logic                   deep_standby_enable_o,
  output logic                   deep_standby_active_o
);

  // ----------------------------------------------------------------
  // elaboration checks on widths and field positions
  // ----------------------------------------------------------------
  initial begin
    if (DATA_W != WORD_W) begin
      $error("display_enhance_standby_cmd_regs: DATA_W must be 16");
    end
    if (WORD_W != BYTE_W + BYTE_W) begin
      $error("display_enhance_standby_cmd_regs: word must be two bytes");
    end
    if (SKIN_EN_BIT >= BYTE_W) begin
      $error("display_enhance_standby_cmd_regs: skin tone enable outside the byte");
    end
    if (SKIN_LVL_W != $bits(skin_tone_level_o)) begin
      $error("display_enhance_standby_cmd_regs: skin tone level width mismatch");
    end
    if (SKIN_LVL_LSB + SKIN_LVL_W > BYTE_W) begin
      $error("display_enhance_standby_cmd_regs: skin tone level outside the byte");
    end
    if (NVM_EN_BIT >= BYTE_W) begin
      $error("display_enhance_standby_cmd_regs: nvm enable outside the byte");
    end
    if (BL_ON_BIT >= BYTE_W) begin
      $error("display_enhance_standby_cmd_regs: backlight on bit outside the byte");
    end
    if (BL_SEL_BIT >= BYTE_W) begin
      $error("display_enhance_standby_cmd_regs: backlight select outside the byte");
    end
    if (DS_FLAG_BIT >= BYTE_W) begin
      $error("display_enhance_standby_cmd_regs: standby flag outside the byte");
    end
    if (FLAG_MASK != 8'(1 << DS_FLAG_BIT)) begin
      $error("display_enhance_standby_cmd_regs: flag mask must match the flag bit");
    end
    if (SEQ_KEY_CNT < 2) begin
      $error("display_enhance_standby_cmd_regs: at least two key bytes needed");
    end
    if (int'(SEQ_ACTIVE_IDX) != SEQ_KEY_CNT - 1) begin
      $error("display_enhance_standby_cmd_regs: active flag must sit on the last key");
    end
    if (int'(SEQ_ENABLE_IDX) != SEQ_KEY_CNT) begin
      $error("display_enhance_standby_cmd_regs: enable flag must follow the keys");
    end
    if ($bits(SEQ_KEYS) != SEQ_KEY_CNT * BYTE_W) begin
      $error("display_enhance_standby_cmd_regs: key table width mismatch");
    end
  end

  // ----------------------------------------------------------------
  // command framing
  // ----------------------------------------------------------------
  cmd_state_e  state_reg;
  cmd_state_e  state_next;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_next;
  logic [7:0]  idx_reg;
  logic [7:0]  idx_next;
  logic        param_we;
  logic [7:0]  param_byte;
  logic        cmd_we;
  path_e       path;

  assign path   = path_e'(path_serial_i);
  assign cmd_we = wr_i && !dc_i;
  // only the low byte of a parameter word carries content on either path
  assign param_byte = wr_data_i[BYTE_W-1:0];

  always_comb begin
    state_next = state_reg;
    cmd_next   = cmd_reg;
    idx_next   = idx_reg;
    param_we   = 1'b0;
    if (sw_reset_i) begin
      state_next = ST_IDLE;
      cmd_next   = REG_RESET;
      idx_next   = REG_RESET;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_we) begin
            state_next = ST_PARAM;
            if (path == PATH_SERIAL) begin
              cmd_next = wr_data_i[WORD_W-1:BYTE_W];
              idx_next = wr_data_i[BYTE_W-1:0];
            end else begin
              cmd_next = wr_data_i[BYTE_W-1:0];
              idx_next = REG_RESET;
            end
          end
        end
        ST_PARAM: begin
          if (cmd_we) begin
            if (path == PATH_SERIAL) begin
              cmd_next = wr_data_i[WORD_W-1:BYTE_W];
              idx_next = wr_data_i[BYTE_W-1:0];
            end else begin
              cmd_next = wr_data_i[BYTE_W-1:0];
              idx_next = REG_RESET;
            end
          end else if (wr_i && dc_i) begin
            param_we = 1'b1;
            if ((path == PATH_PACKET) && (idx_reg != SEQ_IDX_MAX)) begin
              idx_next = idx_reg + 8'h01;
            end
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      cmd_reg   <= REG_RESET;
      idx_reg   <= REG_RESET;
    end else begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
      idx_reg   <= idx_next;
    end
  end

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  logic we_skin;
  logic we_nvm;
  logic we_bl;
  logic we_seq;

  // no sleep or display mode gating on any write
  always_comb begin
    we_skin = 1'b0;
    we_nvm  = 1'b0;
    we_bl   = 1'b0;
    we_seq  = 1'b0;
    if (!param_we) begin
      we_skin = 1'b0;
    end else if ((cmd_reg == CMD_SKIN_TONE) && (idx_reg == REG_RESET)) begin
      we_skin = 1'b1;
    end else if ((cmd_reg == CMD_NVM_ADDR) && (idx_reg == REG_RESET)) begin
      we_nvm = 1'b1;
    end else if ((cmd_reg == CMD_BACKLIGHT) && (idx_reg == REG_RESET)) begin
      we_bl = 1'b1;
    end else if (cmd_reg == CMD_STANDBY) begin
      we_seq = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // deep standby key tracking
  // ----------------------------------------------------------------
  logic lead_ok;
  logic keys_ok;

  standby_key_tracker #(
    .KEY_CNT (SEQ_KEY_CNT)
  ) u_keys (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .clear_i    (sw_reset_i),
    .param_we_i (we_seq),
    .idx_i      (idx_reg),
    .data_i     (param_byte),
    .lead_ok_o  (lead_ok),
    .keys_ok_o  (keys_ok)
  );

  // ----------------------------------------------------------------
  // register fields
  // ----------------------------------------------------------------
  logic       skin_en_reg;
  logic       skin_en_next;
  logic [1:0] skin_lvl_reg;
  logic [1:0] skin_lvl_next;
  logic       nvm_en_reg;
  logic       nvm_en_next;
  logic       bl_on_reg;
  logic       bl_on_next;
  logic       bl_sel_reg;
  logic       bl_sel_next;
  logic       ds_en_reg;
  logic       ds_en_next;
  logic       ds_act_reg;
  logic       ds_act_next;

  always_comb begin
    skin_en_next  = skin_en_reg;
    skin_lvl_next = skin_lvl_reg;
    nvm_en_next   = nvm_en_reg;
    bl_on_next    = bl_on_reg;
    bl_sel_next   = bl_sel_reg;
    ds_en_next    = ds_en_reg;
    ds_act_next   = ds_act_reg;
    if (sw_reset_i) begin
      skin_en_next  = 1'b0;
      skin_lvl_next = '0;
      nvm_en_next   = 1'b0;
      bl_on_next    = 1'b0;
      bl_sel_next   = 1'b0;
      ds_en_next    = 1'b0;
      ds_act_next   = 1'b0;
    end else begin
      if (we_skin) begin
        skin_en_next  = param_byte[SKIN_EN_BIT];
        skin_lvl_next = param_byte[SKIN_LVL_LSB +: SKIN_LVL_W];
      end
      if (we_nvm) begin
        nvm_en_next = param_byte[NVM_EN_BIT];
      end
      if (we_bl) begin
        bl_on_next  = param_byte[BL_ON_BIT];
        bl_sel_next = param_byte[BL_SEL_BIT];
      end
      // flag bits only count after the key bytes lined up
      if (we_seq && (idx_reg == SEQ_ACTIVE_IDX) && lead_ok) begin
        ds_act_next = param_byte[DS_FLAG_BIT];
      end
      if (we_seq && (idx_reg == SEQ_ENABLE_IDX) && keys_ok) begin
        ds_en_next = param_byte[DS_FLAG_BIT];
      end
    end
  end

  // only the documented fields have flops; other parameter bits are not stored
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      skin_en_reg  <= 1'b0;
      skin_lvl_reg <= '0;
      nvm_en_reg   <= 1'b0;
      bl_on_reg    <= 1'b0;
      bl_sel_reg   <= 1'b0;
      ds_en_reg    <= 1'b0;
      ds_act_reg   <= 1'b0;
    end else begin
      skin_en_reg  <= skin_en_next;
      skin_lvl_reg <= skin_lvl_next;
      nvm_en_reg   <= nvm_en_next;
      bl_on_reg    <= bl_on_next;
      bl_sel_reg   <= bl_sel_next;
      ds_en_reg    <= ds_en_next;
      ds_act_reg   <= ds_act_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign skin_tone_enable_o       = skin_en_reg;
  assign skin_tone_level_o        = skin_lvl_reg;
  assign nvm_addr_set_enable_o    = nvm_en_reg;
  assign backlight_output_on_o    = bl_on_reg;
  assign backlight_level_select_o = bl_sel_reg;
  assign deep_standby_enable_o    = ds_en_reg;
  assign deep_standby_active_o    = ds_act_reg;

endmodule

`default_nettype wire

// file: display_enhance_standby_cmd_regs_monitor.sv
// checker for the bank 0 command registers, bound to the top module
// assumes one clock domain and the asynchronous active low reset
`timescale 1ns/100ps
`default_nettype none
module display_enhance_standby_cmd_regs_checker
  import disp_cmd_pkg::*;
#(
  parameter int DATA_W = WORD_W
) (
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic              sw_reset_i,
  input wire logic              path_serial_i,
  input wire logic              wr_i,
  input wire logic              dc_i,
  input wire logic [DATA_W-1:0] wr_data_i,
  input wire logic              skin_tone_enable_o,
  input wire logic [1:0]        skin_tone_level_o,
  input wire logic              nvm_addr_set_enable_o,
  input wire logic              backlight_output_on_o,
  input wire logic              backlight_level_select_o,
  input wire logic              deep_standby_enable_o,
  input wire logic              deep_standby_active_o
);
  logic [7:0] outs;
  assign outs = {skin_tone_enable_o, skin_tone_level_o, nvm_addr_set_enable_o,
                 backlight_output_on_o, backlight_level_select_o,
                 deep_standby_enable_o, deep_standby_active_o};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ----
  // field updates and holds
  // ----
  a_sw_clears_all: assert property (sw_reset_i |=> outs == 8'h00)
    else $error("fields not cleared by software reset");
  a_idle_holds: assert property (!wr_i && !sw_reset_i |=> $stable(outs))
    else $error("fields changed without a write");
  a_cmd_holds: assert property (wr_i && !dc_i && !sw_reset_i |=> $stable(outs))
    else $error("fields changed on a command word");
  a_serial_skin_tone: assert property (
    (wr_i && !dc_i && path_serial_i && wr_data_i == 16'he400 && !sw_reset_i) ##1
    (wr_i && dc_i && path_serial_i && !sw_reset_i) |=>
    {skin_tone_enable_o, skin_tone_level_o} == {$past(wr_data_i[4]), $past(wr_data_i[1:0])})
    else $error("serial skin tone write wrong");
  a_packet_skin_tone: assert property (
    (wr_i && !dc_i && !path_serial_i && wr_data_i[7:0] == 8'he4 && !sw_reset_i) ##1
    (wr_i && dc_i && !path_serial_i && !sw_reset_i) |=>
    {skin_tone_enable_o, skin_tone_level_o} == $past({wr_data_i[4], wr_data_i[1:0]}))
    else $error("packet skin tone write wrong");
  a_backlight_write: assert property (
    (wr_i && !dc_i && path_serial_i && wr_data_i == 16'hee00 && !sw_reset_i) ##1
    (wr_i && dc_i && path_serial_i && !sw_reset_i) |=>
    {backlight_level_select_o, backlight_output_on_o} == $past({wr_data_i[4], wr_data_i[0]}))
    else $error("backlight write wrong");
  a_nvm_enable_write: assert property (
    (wr_i && !dc_i && path_serial_i && wr_data_i == 16'hea00 && !sw_reset_i) ##1
    (wr_i && dc_i && path_serial_i && !sw_reset_i) |=>
    nvm_addr_set_enable_o == $past(wr_data_i[0]))
    else $error("nvm enable write wrong");
  a_standby_rise: assert property ($rose(deep_standby_enable_o) |->
    $past(wr_i && dc_i && wr_data_i[7] && !sw_reset_i))
    else $error("deep standby enable rose without a flag write");
  a_active_rise: assert property ($rose(deep_standby_active_o) |->
    $past(wr_i && dc_i && wr_data_i[7] && !sw_reset_i))
    else $error("deep standby active rose without a flag write");
endmodule
bind display_enhance_standby_cmd_regs display_enhance_standby_cmd_regs_checker #(
  .DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

// file: host_link_model.sv
// host controller model: sends command and parameter words
// assumes its tasks are called from one process of the testbench
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
  input  wire logic   clk_i,
  output logic        serial_o,
  output logic        wr_o,
  output logic        dc_o,
  output logic [15:0] data_o
);
  initial begin
    serial_o = 1'b0;
    wr_o     = 1'b0;
    dc_o     = 1'b0;
    data_o   = 16'h0000;
  end
  // one word per edge, held until the next edge
  task automatic put(input logic s, input logic dc, input logic [15:0] d);
    @(posedge clk_i);
    serial_o <= s;
    wr_o     <= 1'b1;
    dc_o     <= dc;
    data_o   <= d;
  endtask
  // released bus shows a toggled pattern
  task automatic rel();
    @(posedge clk_i);
    wr_o   <= 1'b0;
    data_o <= ~data_o;
  endtask
endmodule
`default_nettype wire

// file: test_display_enhance_standby_cmd_regs.sv
// self-checking bench for the bank 0 command registers
// assumes the host model drives the command port
`timescale 1ns/100ps
`default_nettype none
module test_display_enhance_standby_cmd_regs;
  import disp_cmd_pkg::*;
  logic        clk_i      = 1'b0;
  logic        resetn_i   = 1'b0;
  logic        sw_reset_i = 1'b0;
  logic        serial;
  logic        wr;
  logic        dc;
  logic [15:0] data;
  logic [15:0] r;
  wire logic [7:0] outs;
  logic [7:0]  exp_v;
  logic [7:0]  note_q[$];
  logic [7:0]  keys[5] = '{8'h77, 8'h01, 8'h00, 8'h00, 8'h00};
  int          fail_count = 0;
  int          n_compared = 0;
  int          seed       = 8;
  always #10 clk_i = ~clk_i;
  host_link_model host (.clk_i(clk_i), .serial_o(serial), .wr_o(wr), .dc_o(dc), .data_o(data));
  display_enhance_standby_cmd_regs dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .sw_reset_i(sw_reset_i), .path_serial_i(serial), .wr_i(wr), .dc_i(dc), .wr_data_i(data),
    .skin_tone_enable_o(outs[7]), .skin_tone_level_o(outs[6:5]),
    .nvm_addr_set_enable_o(outs[4]), .backlight_output_on_o(outs[3]),
    .backlight_level_select_o(outs[2]), .deep_standby_enable_o(outs[1]),
    .deep_standby_active_o(outs[0]));
  // ----
  // tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("Error outputs expected %h seen %h", exp, seen);
      fail_count++;
    end
  endtask
  task automatic note();
    host.rel();
    note_q.push_back(exp_v);
  endtask
  task automatic wr1(input logic s, input logic [15:0] c, input logic [15:0] p);
    host.put(s, 1'b0, c);
    host.put(s, 1'b1, p);
    note();
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge clk_i) begin
    if (note_q.size() > 0)
      check(outs, note_q.pop_front());
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    exp_v = 8'h00;
    note();
    exp_v = 8'he0;
    wr1(1'b0, 16'h00e4, 16'h00ff);
    exp_v = 8'hec;
    wr1(1'b1, 16'hee00, 16'hab11);
    exp_v = 8'he0;
    wr1(1'b1, 16'hee00, 16'hff00);
    exp_v = 8'hf0;
    wr1(1'b1, 16'hea00, 16'h0001);
    host.put(1'b0, 1'b0, 16'h00ff);
    for (int i = 0; i < 5; i++)
      host.put(1'b0, 1'b1, {8'h00, keys[i]});
    exp_v = 8'hf2;
    host.put(1'b0, 1'b1, 16'h0080);
    note();
    exp_v = 8'hf3;
    wr1(1'b1, 16'hff04, 16'h0080);
    @(posedge clk_i);
    sw_reset_i <= 1'b1;
    @(posedge clk_i);
    sw_reset_i <= 1'b0;
    exp_v = 8'h00;
    note_q.push_back(exp_v);
    wr1(1'b1, 16'hff05, 16'h0080);
    for (int i = 0; i < 6; i++) begin
      r = 16'($random(seed));
      exp_v = {r[4], r[1:0], 5'h00};
      wr1(1'b1, 16'he400, r);
    end
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    exp_v = 8'h00;
    note();
    repeat (3) @(posedge clk_i);
    results();
  end
  initial begin
    repeat (500) @(posedge clk_i);
    fail_count++;
    results();
  end
endmodule
`default_nettype wire
